/* rtl/osd_top.sv */
`timescale 1ns/1ps
module osd_top
  import osd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       main_osc_tick,
  input  wire logic       sfr_wr,
  input  wire logic [3:0] sfr_sel,
  input  wire logic [7:0] sfr_wdata,
  output logic            wr_accept,
  output logic            wr_refuse,
  output logic            osc_event_req,
  output logic            osc_reset_req,
  output logic            stop_detect_enable,
  output logic            detect_action_select,
  output logic            onchip_osc_select,
  output logic            stop_detect_flag,
  output logic            main_clock_monitor,
  output logic            main_clock_off,
  output logic            periph_clock_wait_gate,
  output logic            cpu_sub_select,
  output logic            pll_select,
  output logic            clock_change_lock,
  output logic            onchip_osc_run,
  output logic            periph_onchip,
  output logic [3:0]      cpu_clk_src,
  output logic [3:0]      unlock_bits
);

  osd_if ifc ();

  logic     enable_r;
  logic     action_r;
  logic     osc_sel_r;
  logic     flag_r;
  logic     monitor_r;
  logic     main_off_r;
  logic     wait_gate_r;
  logic     cpu_sub_r;
  logic     pll_sel_r;
  logic     lock_r;
  logic     osc_run_r;
  logic     periph_fb_r;
  logic     event_r;
  logic     reset_req_r;
  logic     accept_r;
  logic     refuse_r;
  osd_src_t src_r;
  osd_src_t src_nxt;
  logic     allowed;
  logic     wr_ok;
  logic     armed;
  logic     stop_go;
  logic     resume_go;
  logic     from_main;
  logic     from_pll;
  logic     from_sub;
  osd_sel_t sel;

  // ==========================================================
  // sub modules
  osd_detect u_detect (
    .clk  (clk),
    .nrst (nrst),
    .bus  (ifc.det)
  );

  osd_protect u_protect (
    .clk  (clk),
    .nrst (nrst),
    .bus  (ifc.prot)
  );

  assign sel            = osd_sel_t'(sfr_sel);
  assign ifc.main_tick  = main_osc_tick;
  assign ifc.sfr_wr     = sfr_wr;
  assign ifc.prot_wr    = sfr_wr && sel == SEL_PROT;
  assign ifc.prot_wdata = sfr_wdata[3:0];

  // ==========================================================
  // write protection gate
  always_comb
  begin
    unique case (sel)
      SEL_CLK0, SEL_CLK2, SEL_PLL, SEL_CLKX: allowed = ifc.unlock[PROT_CLOCK_BIT];
      SEL_PM2, SEL_MODE:                     allowed = ifc.unlock[PROT_MODE_BIT];
      SEL_PORT:                              allowed = ifc.unlock[PROT_PORT_BIT];
      SEL_VOLT:                              allowed = ifc.unlock[PROT_VOLT_BIT];
      default:                               allowed = 1'b1;
    endcase
  end

  assign wr_ok = sfr_wr && allowed;

  // accept or refuse report, one pulse per write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      accept_r <= RST_BIT;
      refuse_r <= RST_BIT;
    end
    else
    begin
      accept_r <= wr_ok;
      refuse_r <= sfr_wr && !allowed;
    end
  end

  // ==========================================================
  // detection decision
  assign armed     = enable_r && !flag_r;
  assign stop_go   = armed && ifc.stop_ev;
  assign resume_go = armed && ifc.resume_ev;
  assign from_sub  = cpu_sub_r;
  assign from_pll  = !cpu_sub_r && !osc_sel_r && pll_sel_r;
  assign from_main = !cpu_sub_r && !osc_sel_r && !pll_sel_r;

  // ==========================================================
  // clock_control_0 and pll_control, frozen by the lock
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      main_off_r  <= RST_BIT;
      wait_gate_r <= RST_BIT;
      cpu_sub_r   <= RST_BIT;
      pll_sel_r   <= RST_BIT;
    end
    else if (wr_ok && !lock_r)
    begin
      if (sel == SEL_CLK0)
      begin
        main_off_r  <= sfr_wdata[CC0_MAIN_OFF_BIT];
        wait_gate_r <= sfr_wdata[CC0_WAIT_GATE_BIT];
        cpu_sub_r   <= sfr_wdata[CC0_CPU_SUB_BIT];
      end
      if (sel == SEL_PLL)
        pll_sel_r <= sfr_wdata[PLL_SEL_BIT];
    end
  end

  // clock change lock in proc_mode_2
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      lock_r <= RST_BIT;
    else if (wr_ok && sel == SEL_PM2)
      lock_r <= sfr_wdata[PM2_LOCK_BIT];
  end

  // ==========================================================
  // clock_control_2 software fields
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      enable_r <= RST_BIT;
      action_r <= RST_BIT;
    end
    else if (wr_ok && sel == SEL_CLK2)
    begin
      if (!lock_r)
        enable_r <= sfr_wdata[CC2_ENABLE_BIT];
      action_r <= sfr_wdata[CC2_ACTION_BIT];
    end
  end

  // onchip select: hardware sets on main source stop only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      osc_sel_r <= RST_BIT;
    else if (stop_go && action_r && from_main)
      osc_sel_r <= 1'b1;
    else if (wr_ok && sel == SEL_CLK2)
      osc_sel_r <= sfr_wdata[CC2_OSC_SEL_BIT];
  end

  // detect flag: hardware sets, software writes 0 to clear, set wins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flag_r <= RST_BIT;
    else if ((stop_go || resume_go) && action_r)
      flag_r <= 1'b1;
    else if (wr_ok && sel == SEL_CLK2 && !sfr_wdata[CC2_FLAG_BIT])
      flag_r <= 1'b0;
  end

  // main clock monitor
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      monitor_r <= RST_BIT;
    else if (stop_go && action_r)
      monitor_r <= 1'b1;
    else if (resume_go && action_r)
      monitor_r <= 1'b0;
  end

  // ==========================================================
  // onchip oscillator start and peripheral fallback
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_run_r   <= RST_BIT;
      periph_fb_r <= RST_BIT;
    end
    else if (stop_go && action_r && (from_main || from_sub))
    begin
      osc_run_r   <= 1'b1;
      periph_fb_r <= 1'b1;
    end
    else if (wr_ok && sel == SEL_CLK2)
    begin
      osc_run_r   <= sfr_wdata[CC2_OSC_SEL_BIT] || osc_run_r; // write 0 keeps its value, 1 starts it
      periph_fb_r <= sfr_wdata[CC2_OSC_SEL_BIT];              // follows the select bit
    end
    else if (osc_sel_r)
      osc_run_r <= 1'b1;
  end

  // ==========================================================
  // event request, not gated by any mask
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      event_r     <= RST_BIT;
      reset_req_r <= RST_BIT;
    end
    else
    begin
      event_r     <= (stop_go || resume_go) && action_r;
      reset_req_r <= stop_go && !action_r;
    end
  end

  // cpu clock source, sub clock keeps the cpu in low speed mode
  always_comb
  begin
    if (cpu_sub_r)
      src_nxt = SRC_SUB;
    else if (osc_sel_r)
      src_nxt = SRC_ONCHIP;
    else if (pll_sel_r)
      src_nxt = SRC_PLL;
    else
      src_nxt = SRC_MAIN;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      src_r <= SRC_MAIN;
    else
      src_r <= src_nxt;
  end

  // ==========================================================
  // outputs
  assign wr_accept              = accept_r;
  assign wr_refuse              = refuse_r;
  assign osc_event_req          = event_r;
  assign osc_reset_req          = reset_req_r;
  assign stop_detect_enable     = enable_r;
  assign detect_action_select   = action_r;
  assign onchip_osc_select      = osc_sel_r;
  assign stop_detect_flag       = flag_r;
  assign main_clock_monitor     = monitor_r;
  assign main_clock_off         = main_off_r;
  assign periph_clock_wait_gate = wait_gate_r;
  assign cpu_sub_select         = cpu_sub_r;
  assign pll_select             = pll_sel_r;
  assign clock_change_lock      = lock_r;
  assign onchip_osc_run         = osc_run_r;
  assign periph_onchip          = periph_fb_r;
  assign cpu_clk_src            = src_r;
  assign unlock_bits            = ifc.unlock;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence main_stop_s;
    ifc.stop_ev && enable_r && !flag_r && action_r && from_main;
  endsequence

  sequence fallback_s;
    osc_sel_r && osc_run_r && periph_onchip ##1 src_r == SRC_ONCHIP;
  endsequence

  main_stop_flags_a: assert property (main_stop_s |=> event_r && flag_r && monitor_r)
    else $error("main stop flags missing");
  main_fallback_a: assert property (main_stop_s |=> fallback_s)
    else $error("no fallback to onchip oscillator");
  pll_select_kept_a: assert property (ifc.stop_ev && armed && action_r && from_pll |=>
    !osc_sel_r && event_r && monitor_r)
    else $error("pll stop changed select");
  resume_monitor_a: assert property (ifc.resume_ev && armed && action_r |=>
    !monitor_r && flag_r && $stable(osc_sel_r))
    else $error("restart handling wrong");
  flag_blocks_a: assert property (flag_r && !(sfr_wr && sel == SEL_CLK2) [*2] |-> !event_r)
    else $error("event while flag set");
  low_speed_a: assert property (ifc.stop_ev && armed && action_r && from_sub |=>
    osc_run_r && periph_onchip ##1 src_r == SRC_SUB)
    else $error("low speed stop handling wrong");
  clock_guard_a: assert property (sfr_wr && sel == SEL_CLK0 && !ifc.unlock[PROT_CLOCK_BIT] |=>
    refuse_r && $stable(main_off_r) && $stable(cpu_sub_r))
    else $error("clock write not blocked");
  volt_guard_a: assert property (sfr_wr && sel == SEL_VOLT |=> accept_r == $past(ifc.unlock[PROT_VOLT_BIT]))
    else $error("voltage guard wrong");
  port_guard_a: assert property (sfr_wr && sel inside {SEL_PORT, SEL_MODE} |=> refuse_r != accept_r)
    else $error("guard answer missing");
  lock_freeze_a: assert property (lock_r && sfr_wr && sel == SEL_CLK2 |=> $stable(enable_r))
    else $error("locked enable changed");
  reset_action_a: assert property (ifc.stop_ev && armed && !action_r |=> osc_reset_req && !event_r)
    else $error("reset action wrong");

endmodule

/* rtl/osd_pkg.sv */
package osd_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int STOP_TIME_NS  = 1000; // no main tick for this long means stopped
  localparam int STOP_CYC      = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // field positions in the written byte
  localparam int CC0_WAIT_GATE_BIT = 2;
  localparam int CC0_MAIN_OFF_BIT  = 5;
  localparam int CC0_CPU_SUB_BIT   = 7;
  localparam int CC2_ENABLE_BIT    = 0;
  localparam int CC2_OSC_SEL_BIT   = 1;
  localparam int CC2_FLAG_BIT      = 2;
  localparam int CC2_ACTION_BIT    = 7;
  localparam int PLL_SEL_BIT       = 7;
  localparam int PM2_LOCK_BIT      = 1;
  localparam int PROT_CLOCK_BIT    = 0;
  localparam int PROT_MODE_BIT     = 1;
  localparam int PROT_PORT_BIT     = 2;
  localparam int PROT_VOLT_BIT     = 3;

  // ==========================================================
  // reset values
  localparam logic       RST_BIT    = 1'b0;
  localparam logic [3:0] RST_UNLOCK = 4'h0;
  localparam logic [7:0] RST_CNT    = 8'h00;

  // ==========================================================
  // write target of a special register write
  typedef enum logic [3:0] {
    SEL_CLK0  = 4'h0, // clock_control_0
    SEL_CLK2  = 4'h1, // clock_control_2
    SEL_PLL   = 4'h2, // pll_control
    SEL_CLKX  = 4'h3, // clock_control_1, onchip_osc_control, periph/can clock select
    SEL_PM2   = 4'h4, // proc_mode_2
    SEL_MODE  = 4'h5, // proc_mode_0/1, timer_b2_special_mode, inverter_control_0/1
    SEL_PORT  = 4'h6, // port9_direction, port_control, serial4_control, noise_filter_disable
    SEL_VOLT  = 4'h7, // voltage_detect_control, voltage_down_int_control
    SEL_PROT  = 4'h8, // write_protect_register
    SEL_OTHER = 4'h9  // any unguarded register
  } osd_sel_t;

  // one-hot cpu clock source
  typedef enum logic [3:0] {
    SRC_MAIN   = 4'b0001,
    SRC_PLL    = 4'b0010,
    SRC_ONCHIP = 4'b0100,
    SRC_SUB    = 4'b1000
  } osd_src_t;

  // main oscillator supervisor state
  typedef enum logic [1:0] {
    OSC_RUN  = 2'b01,
    OSC_STOP = 2'b10
  } osd_osc_st_t;

endpackage

/* rtl/osd_if.sv */
`timescale 1ns/1ps
interface osd_if;
  logic       main_tick;
  logic       stop_ev;
  logic       resume_ev;
  logic       osc_stopped;
  logic       prot_wr;
  logic [3:0] prot_wdata;
  logic       sfr_wr;
  logic [3:0] unlock;

  modport det  (input main_tick, output stop_ev, resume_ev, osc_stopped);
  modport prot (input prot_wr, prot_wdata, sfr_wr, output unlock);
  modport ctl  (output main_tick, prot_wr, prot_wdata, sfr_wr, input stop_ev, resume_ev, osc_stopped, unlock);
endinterface

/* rtl/osd_detect.sv */
`timescale 1ns/1ps
module osd_detect
  import osd_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  osd_if.det        bus
);

  osd_osc_st_t st_r;
  logic [7:0]  cnt_r;
  logic        stop_r;
  logic        resume_r;

  // ==========================================================
  // stop and restart watch
  // silence counter, cleared by every main oscillator tick
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= RST_CNT;
    else if (bus.main_tick || st_r == OSC_STOP)
      cnt_r <= RST_CNT;
    else
      cnt_r <= cnt_r + 8'h01;
  end

  // state and one-cycle events
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r     <= OSC_RUN;
      stop_r   <= RST_BIT;
      resume_r <= RST_BIT;
    end
    else
    begin
      stop_r   <= 1'b0;
      resume_r <= 1'b0;
      unique case (st_r)
        OSC_RUN:
          if (!bus.main_tick && cnt_r == 8'(STOP_CYC - 1))
          begin
            st_r   <= OSC_STOP;
            stop_r <= 1'b1;
          end
        OSC_STOP:
          if (bus.main_tick)
          begin
            st_r     <= OSC_RUN;
            resume_r <= 1'b1;
          end
      endcase
    end
  end

  assign bus.stop_ev     = stop_r;
  assign bus.resume_ev   = resume_r;
  assign bus.osc_stopped = (st_r == OSC_STOP);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  stop_after_silence_a: assert property (stop_r |-> $past(cnt_r) == 8'(STOP_CYC - 1) && $past(st_r) == OSC_RUN)
    else $error("stop event without silence");
  resume_on_tick_a: assert property (st_r == OSC_STOP && bus.main_tick |=> resume_r && st_r == OSC_RUN)
    else $error("restart not reported");

endmodule

/* rtl/osd_protect.sv */
`timescale 1ns/1ps
module osd_protect
  import osd_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  osd_if.prot       bus
);

  logic [3:0] unlock_r;

  // ==========================================================
  // unlock bits, all locked after reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      unlock_r <= RST_UNLOCK;
    else if (bus.prot_wr)
      unlock_r <= bus.prot_wdata;
    else if (bus.sfr_wr)
      unlock_r[PROT_PORT_BIT] <= 1'b0;
  end

  assign bus.unlock = unlock_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  port_auto_clear_a: assert property (bus.sfr_wr && !bus.prot_wr |=> !unlock_r[PROT_PORT_BIT])
    else $error("port unlock survived a write");
  sticky_unlock_a: assert property (bus.sfr_wr && !bus.prot_wr |=>
    unlock_r[PROT_CLOCK_BIT] == $past(unlock_r[PROT_CLOCK_BIT]) && unlock_r[PROT_VOLT_BIT] == $past(unlock_r[PROT_VOLT_BIT]))
    else $error("sticky unlock changed");

endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// bench for the oscillator supervisor and write guard
module tb_top
  import osd_pkg::*;
;
  logic       clk;
  logic       nrst;
  logic       main_osc_tick;
  logic       tick_en;
  logic       sfr_wr;
  logic [3:0] sfr_sel;
  logic [7:0] sfr_wdata;
  logic       wr_accept, wr_refuse, osc_event_req, osc_reset_req;
  logic       stop_detect_enable, detect_action_select, onchip_osc_select, stop_detect_flag;
  logic       main_clock_monitor, main_clock_off, periph_clock_wait_gate, cpu_sub_select;
  logic       pll_select, clock_change_lock, onchip_osc_run, periph_onchip;
  logic [3:0] cpu_clk_src;
  logic [3:0] unlock_bits;
  logic       ev;
  logic       rs;
  int         miscompares;
  int         comparisons;
  osd_sel_t   grp_sel [4];

  // ==========================================================
  // device under test
  osd_top u_dut (
    .clk, .nrst, .main_osc_tick, .sfr_wr, .sfr_sel, .sfr_wdata, .wr_accept, .wr_refuse,
    .osc_event_req, .osc_reset_req, .stop_detect_enable, .detect_action_select,
    .onchip_osc_select, .stop_detect_flag, .main_clock_monitor, .main_clock_off,
    .periph_clock_wait_gate, .cpu_sub_select, .pll_select, .clock_change_lock,
    .onchip_osc_run, .periph_onchip, .cpu_clk_src, .unlock_bits
  );

  // ==========================================================
  // clock and main oscillator activity
  always #4 clk = ~clk;

  // toggling marker while the oscillator runs, flat when stopped
  always @(posedge clk)
  begin
    #1;
    main_osc_tick = tick_en ? ~main_osc_tick : 1'b0;
  end

  // ==========================================================
  // compare and access tasks
  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe, answer seen right after the taking edge
  task automatic wr(input osd_sel_t sel, input logic [7:0] data, input logic ok);
    @(posedge clk);
    #1;
    sfr_wr = 1'b1;
    sfr_sel = sel;
    sfr_wdata = data;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    chk1("wr_accept", ok, wr_accept);
    chk1("wr_refuse", ~ok, wr_refuse);
  endtask

  // waits a bounded span for an event or reset request pulse
  task automatic wait_req();
    ev = 1'b0;
    rs = 1'b0;
    repeat (300)
    begin
      @(posedge clk);
      #1;
      ev = ev | osc_event_req;
      rs = rs | osc_reset_req;
      if (ev || rs)
        break;
    end
  endtask

  task automatic do_reset();
    tick_en = 1'b1;
    sfr_wr = 1'b0;
    nrst = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
  endtask

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // watchdog against a hang
  initial
  begin
    #(8 * 20000);
    miscompares++;
    $display("ERROR watchdog expected finish seen timeout");
    test_done();
  end

  // ==========================================================
  // test sequence
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    tick_en = 1'b1;
    main_osc_tick = 1'b0;
    sfr_wr = 1'b0;
    sfr_sel = 4'h0;
    sfr_wdata = 8'h00;
    miscompares = 0;
    comparisons = 0;
    grp_sel = '{SEL_CLK0, SEL_MODE, SEL_PORT, SEL_VOLT};
    do_reset();
    chk4("unlock_bits", 4'h0, unlock_bits);
    chk4("cpu_clk_src", SRC_MAIN, cpu_clk_src);
    chk1("stop_detect_flag", 1'b0, stop_detect_flag);
    $display("test reset done");

    // each group refused while locked, accepted once its bit is set
    for (int i = 0; i < 4; i++)
    begin
      wr(grp_sel[i], 8'h00, 1'b0);
      wr(SEL_PROT, 8'h01 << i, 1'b1);
      wr(grp_sel[i], 8'h00, 1'b1);
      wr(SEL_PROT, 8'h00, 1'b1);
    end
    $display("test groups done");

    // port unlock drops on the next write, the others stay
    wr(SEL_PROT, 8'h0f, 1'b1);
    chk4("unlock_bits", 4'hf, unlock_bits);
    wr(SEL_OTHER, 8'h00, 1'b1);
    chk4("unlock_bits", 4'hb, unlock_bits);
    wr(SEL_CLKX, 8'h00, 1'b1);
    wr(SEL_PORT, 8'h00, 1'b0);
    $display("test self clear done");

    // stop with main source, then restart, then blocked stop
    wr(SEL_CLK2, 8'h81, 1'b1);
    chk1("stop_detect_enable", 1'b1, stop_detect_enable);
    chk1("detect_action_select", 1'b1, detect_action_select);
    tick_en = 1'b0;
    wait_req();
    chk1("osc_event_req", 1'b1, ev);
    chk1("stop_detect_flag", 1'b1, stop_detect_flag);
    chk1("main_clock_monitor", 1'b1, main_clock_monitor);
    chk1("onchip_osc_select", 1'b1, onchip_osc_select);
    chk1("onchip_osc_run", 1'b1, onchip_osc_run);
    chk1("periph_onchip", 1'b1, periph_onchip);
    @(posedge clk);
    #1;
    chk4("cpu_clk_src", SRC_ONCHIP, cpu_clk_src);
    wr(SEL_CLK2, 8'h83, 1'b1);
    chk1("stop_detect_flag", 1'b0, stop_detect_flag);
    tick_en = 1'b1;
    wait_req();
    chk1("osc_event_req", 1'b1, ev);
    chk1("stop_detect_flag", 1'b1, stop_detect_flag);
    chk1("main_clock_monitor", 1'b0, main_clock_monitor);
    chk1("onchip_osc_select", 1'b1, onchip_osc_select);
    wr(SEL_CLK2, 8'h85, 1'b1);
    chk1("periph_onchip", 1'b0, periph_onchip);
    @(posedge clk);
    #1;
    chk4("cpu_clk_src", SRC_MAIN, cpu_clk_src);
    tick_en = 1'b0;
    wait_req();
    chk1("osc_event_req", 1'b0, ev);
    chk1("stop_detect_flag", 1'b1, stop_detect_flag);
    $display("test main source done");

    // stop with pll source keeps the select bit
    do_reset();
    wr(SEL_PROT, 8'h01, 1'b1);
    wr(SEL_PLL, 8'h80, 1'b1);
    chk1("pll_select", 1'b1, pll_select);
    @(posedge clk);
    #1;
    chk4("cpu_clk_src", SRC_PLL, cpu_clk_src);
    wr(SEL_CLK2, 8'h81, 1'b1);
    tick_en = 1'b0;
    wait_req();
    chk1("osc_event_req", 1'b1, ev);
    chk1("stop_detect_flag", 1'b1, stop_detect_flag);
    chk1("main_clock_monitor", 1'b1, main_clock_monitor);
    chk1("onchip_osc_select", 1'b0, onchip_osc_select);
    wr(SEL_CLK2, 8'h87, 1'b1);
    chk1("onchip_osc_select", 1'b1, onchip_osc_select);
    chk1("periph_onchip", 1'b1, periph_onchip);
    @(posedge clk);
    #1;
    chk4("cpu_clk_src", SRC_ONCHIP, cpu_clk_src);
    $display("test pll source done");

    // stop in low speed mode: cpu stays on sub clock
    do_reset();
    wr(SEL_PROT, 8'h01, 1'b1);
    wr(SEL_CLK0, 8'h80, 1'b1);
    chk1("periph_clock_wait_gate", 1'b0, periph_clock_wait_gate);
    chk1("cpu_sub_select", 1'b1, cpu_sub_select);
    wr(SEL_CLK2, 8'h81, 1'b1);
    tick_en = 1'b0;
    wait_req();
    chk1("osc_event_req", 1'b1, ev);
    chk1("onchip_osc_run", 1'b1, onchip_osc_run);
    chk1("periph_onchip", 1'b1, periph_onchip);
    @(posedge clk);
    #1;
    chk4("cpu_clk_src", SRC_SUB, cpu_clk_src);
    $display("test low speed done");

    // action select 0 gives reset request, enable 0 gives nothing
    do_reset();
    wr(SEL_PROT, 8'h01, 1'b1);
    wr(SEL_CLK2, 8'h01, 1'b1);
    tick_en = 1'b0;
    wait_req();
    chk1("osc_reset_req", 1'b1, rs);
    chk1("osc_event_req", 1'b0, ev);
    do_reset();
    tick_en = 1'b0;
    wait_req();
    chk1("osc_reset_req", 1'b0, rs);
    chk1("osc_event_req", 1'b0, ev);
    $display("test action done");

    // clock change lock ignores guarded clock bits
    do_reset();
    wr(SEL_PROT, 8'h03, 1'b1);
    wr(SEL_CLK0, 8'h04, 1'b1);
    chk1("periph_clock_wait_gate", 1'b1, periph_clock_wait_gate);
    wr(SEL_PM2, 8'h02, 1'b1);
    chk1("clock_change_lock", 1'b1, clock_change_lock);
    wr(SEL_CLK2, 8'h01, 1'b1);
    chk1("stop_detect_enable", 1'b0, stop_detect_enable);
    wr(SEL_CLK0, 8'h20, 1'b1);
    chk1("main_clock_off", 1'b0, main_clock_off);
    chk1("periph_clock_wait_gate", 1'b1, periph_clock_wait_gate);
    $display("test lock done");
    test_done();
  end
endmodule
